// file: src/gppa_pkg.sv
// Shared constants and carriers for general purpose port A.
package gppa_pkg;

  // Port width in pins.
  localparam int unsigned PORT_W = 8;

  // Depth of the pin input synchroniser.
  localparam int unsigned SYNC_STAGES = 2;

  // Position of the input-only pin.
  localparam int unsigned INPUT_ONLY_POS = 5;

  // Positions of the two weak current source pins.
  localparam int unsigned CSRC_LO_POS = 2;
  localparam int unsigned CSRC_HI_POS = 3;

  // Pins that have a weak pull-up: 1:0 and 5.
  localparam logic [7:0] PULLUP_MASK = 8'h23;

  // True open-drain pins 7 and 4.
  localparam logic [7:0] OPEN_DRAIN_MASK = 8'h90;

  // The input-only pin, never driven.
  localparam logic [7:0] INPUT_ONLY_MASK = 8'h20;

  // Push-pull pins 6, 3:0.
  localparam logic [7:0] PUSH_PULL_MASK = 8'h4f;

  // Values after reset.
  localparam logic [7:0] DIR_RST   = 8'hff;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] ANSEL_RST = 8'hff;
  localparam logic [7:0] WPU_RST   = 8'h00;
  localparam logic [7:0] IOC_RST   = 8'h00;

  // Register that a write request is aimed at.
  typedef enum logic [2:0] {
    GPPA_SEL_DIR,
    GPPA_SEL_DATA,
    GPPA_SEL_ANSEL,
    GPPA_SEL_WPU,
    GPPA_SEL_IOC
  } gppa_sel_e;

  // One write request from the processor side.
  typedef struct packed {
    logic       wr;
    gppa_sel_e  sel;
    logic [7:0] data;
    logic [7:0] mask;
  } gppa_wr_s;

  // One peripheral output source for all pins.
  typedef struct packed {
    logic [7:0] en;
    logic [7:0] dat;
  } gppa_periph_s;

  // Register read-back view.
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] data;
    logic [7:0] ansel;
    logic [7:0] wpu;
    logic [7:0] ioc;
  } gppa_rd_s;

endpackage : gppa_pkg

// file: src/gppa_sync.sv
`timescale 1ns/1ns
// Multi-stage synchroniser for a group of level inputs.
module gppa_sync #(
  parameter int unsigned WIDTH  = 8,
  parameter int unsigned STAGES = 2
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // Shift chain; only the next stage reads each earlier stage.
  logic [WIDTH-1:0] chain [STAGES];

  // Shift the inputs through the chain; reset loads a constant.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < STAGES; i++)
        chain[i] <= '0;
    end
    else
    begin
      chain[0] <= d;
      for (int i = 1; i < STAGES; i++)
        chain[i] <= chain[i-1];
    end
  end

  // The last stage is the only one seen by the outside.
  assign q = chain[STAGES-1];

endmodule : gppa_sync

// file: src/gppa_port.sv
`timescale 1ns/1ns
module gppa_port (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  gppa_pkg::gppa_wr_s         wr_req,
  output gppa_pkg::gppa_rd_s         rd_view,
  input  gppa_pkg::gppa_periph_s     periph_hi,
  input  gppa_pkg::gppa_periph_s     periph_lo,
  input  wire logic                  external_reset_pin,
  input  wire logic                  pullup_global_disable,
  input  wire logic [7:0]            pin_in,
  output logic      [7:0]            pin_out,
  output logic      [7:0]            pin_oe,
  output logic      [7:0]            pullup_on,
  output logic      [1:0]            current_source_on,
  output logic      [7:0]            change_event
);

  // Reset synchroniser stages; the second one resets the design.
  logic       rst_meta_n;
  logic       rst_sync_n;

  // Software registers.
  logic [7:0] pin_direction_bits;
  logic [7:0] port_latch;
  logic [7:0] analog_select_bits;
  logic [7:0] pullup_enable_bits;
  logic [7:0] change_interrupt_enables;

  // Global pull-up disable, caught once after reset release.
  logic       pu_gdis;
  logic       strap_taken;

  // Synchronised pin levels and their previous value.
  logic [7:0] pin_sync;
  logic [7:0] pin_prev;

  // Digital view of the pins, masked by analog select.
  logic [7:0] port_pin_data;

  // Combinational next values for the pin drivers.
  logic [7:0] next_out;
  logic [7:0] next_oe;

  // Release reset through two flops so all flops leave reset together.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Pins are asynchronous board signals; sample them safely first.
  gppa_sync #(
    .WIDTH  (gppa_pkg::PORT_W),
    .STAGES (gppa_pkg::SYNC_STAGES)
  ) u_pin_sync (
    .core_clk (core_clk),
    .rst_n    (rst_sync_n),
    .d        (pin_in),
    .q        (pin_sync)
  );

  // Analog pins read zero; digital pins read their real level.
  assign port_pin_data = pin_sync & ~analog_select_bits;

  // Direction register; pin 5 is held at one whatever is written.
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      pin_direction_bits <= gppa_pkg::DIR_RST;
    else if (wr_req.wr && wr_req.sel == gppa_pkg::GPPA_SEL_DIR)
    begin
      pin_direction_bits <= (pin_direction_bits & ~wr_req.mask)
                          | (wr_req.data & wr_req.mask)
                          | gppa_pkg::INPUT_ONLY_MASK;
    end
  end

  // Output latch. Unwritten bits take the pin levels as read now, so
  // a write behaves like read-modify-write; analog pins read zero and
  // therefore can lose their latch value, as software must expect.
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      port_latch <= gppa_pkg::LATCH_RST;
    else if (wr_req.wr && wr_req.sel == gppa_pkg::GPPA_SEL_DATA)
    begin
      port_latch <= (port_pin_data & ~wr_req.mask)
                  | (wr_req.data & wr_req.mask);
    end
  end

  // Analog select register; every pin starts in analog mode.
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      analog_select_bits <= gppa_pkg::ANSEL_RST;
    else if (wr_req.wr && wr_req.sel == gppa_pkg::GPPA_SEL_ANSEL)
    begin
      analog_select_bits <= (analog_select_bits & ~wr_req.mask)
                          | (wr_req.data & wr_req.mask);
    end
  end

  // Pull-up enables; bits 3:2 are kept since they steer current sources.
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      pullup_enable_bits <= gppa_pkg::WPU_RST;
    else if (wr_req.wr && wr_req.sel == gppa_pkg::GPPA_SEL_WPU)
    begin
      pullup_enable_bits <= (pullup_enable_bits & ~wr_req.mask)
                          | (wr_req.data & wr_req.mask);
    end
  end

  // Change interrupt enables, one per pin, all off after reset.
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      change_interrupt_enables <= gppa_pkg::IOC_RST;
    else if (wr_req.wr && wr_req.sel == gppa_pkg::GPPA_SEL_IOC)
    begin
      change_interrupt_enables <= (change_interrupt_enables & ~wr_req.mask)
                                | (wr_req.data & wr_req.mask);
    end
  end

  // The global pull-up disable is a strap: caught once after release.
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      strap_taken <= 1'b0;
      pu_gdis     <= 1'b0;
    end
    else if (!strap_taken)
    begin
      strap_taken <= 1'b1;
      pu_gdis     <= pullup_global_disable;
    end
  end

  // Per-pin drive: peripherals outrank the latch, the high source first.
  // Analog select plays no part, so analog pins still drive if asked.
  generate
    for (genvar i = 0; i < gppa_pkg::PORT_W; i++)
    begin : g_pin
      logic val;
      // Pick the value of the strongest enabled source.
      assign val = periph_hi.en[i] ? periph_hi.dat[i] :
                   periph_lo.en[i] ? periph_lo.dat[i] :
                   port_latch[i];
      if (gppa_pkg::INPUT_ONLY_MASK[i])
      begin : g_in_only
        // The input-only pin has no driver at all.
        assign next_oe[i]  = 1'b0;
        assign next_out[i] = 1'b0;
      end
      else if (gppa_pkg::OPEN_DRAIN_MASK[i])
      begin : g_od
        // Only pull low; a one releases the pin to the board.
        assign next_oe[i]  = ~pin_direction_bits[i] & ~val;
        assign next_out[i] = 1'b0;
      end
      else
      begin : g_pp
        // Push-pull: the direction bit alone gates the driver.
        assign next_oe[i]  = ~pin_direction_bits[i];
        assign next_out[i] = val;
      end
    end
  endgenerate

  // Register the pin drivers so the pads see clean edges.
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pin_out <= '0;
      pin_oe  <= '0;
    end
    else
    begin
      pin_out <= next_out;
      pin_oe  <= next_oe;
    end
  end

  // Pull-ups and current sources. A pin set as output never pulls up;
  // the reset-pin select turns on pin 5's pull-up on its own.
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pullup_on         <= '0;
      current_source_on <= '0;
    end
    else
    begin
      pullup_on <= (pullup_enable_bits & gppa_pkg::PULLUP_MASK
                    & pin_direction_bits & {8{~pu_gdis}})
                 | (gppa_pkg::INPUT_ONLY_MASK & {8{external_reset_pin}});
      current_source_on <= {pullup_enable_bits[gppa_pkg::CSRC_HI_POS],
                            pullup_enable_bits[gppa_pkg::CSRC_LO_POS]};
    end
  end

  // Change detection on synchronised levels; one-cycle pulse per pin.
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pin_prev     <= '0;
      change_event <= '0;
    end
    else
    begin
      pin_prev     <= pin_sync;
      change_event <= (pin_sync ^ pin_prev) & change_interrupt_enables;
    end
  end

  // Read-back view, registered; pin 5 direction shows one once out of reset, zero during reset.
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      rd_view <= '0;
    else
    begin
      rd_view.dir   <= pin_direction_bits | gppa_pkg::INPUT_ONLY_MASK;
      rd_view.data  <= port_pin_data;
      rd_view.ansel <= analog_select_bits;
      rd_view.wpu   <= pullup_enable_bits;
      rd_view.ioc   <= change_interrupt_enables;
    end
  end

  // Checks below run on the synchronised reset.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_n);

  a_dir_pin_five: assert property (rd_view.dir[5] == 1'b1 || !$past(rst_sync_n))
    else $error("Input-only pin direction read as zero.");

  a_pin_five_undriven: assert property (!pin_oe[5])
    else $error("Input-only pin was driven.");

  a_push_pull_oe: assert property (
    (pin_oe & gppa_pkg::PUSH_PULL_MASK)
      == (~$past(pin_direction_bits) & gppa_pkg::PUSH_PULL_MASK))
    else $error("Push-pull enable does not follow direction.");

  a_open_drain_low: assert property ((pin_out & gppa_pkg::OPEN_DRAIN_MASK) == 8'h00)
    else $error("Open-drain pin driven high.");

  a_analog_read_zero: assert property (
    $past(rst_sync_n) |-> (rd_view.data & $past(analog_select_bits)) == 8'h00)
    else $error("Analog pin read as one.");

  a_data_write_rmw: assert property (
    (wr_req.wr && wr_req.sel == gppa_pkg::GPPA_SEL_DATA)
      |=> port_latch == (($past(port_pin_data) & ~$past(wr_req.mask))
                         | ($past(wr_req.data) & $past(wr_req.mask))))
    else $error("Latch write is not read-modify-write.");

  a_change_gated: assert property (
    (change_event & ~$past(change_interrupt_enables)) == 8'h00)
    else $error("Change event on a disabled pin.");

  a_pullup_output_off: assert property (
    !pin_direction_bits[0] |=> !pullup_on[0])
    else $error("Pull-up on while pin is an output.");

  a_no_pullup_pins: assert property (
    (pullup_on & ~gppa_pkg::PULLUP_MASK) == 8'h00)
    else $error("Pull-up on a pin that has none.");

  a_priority_hi: assert property (
    (periph_hi.en[0] && !pin_direction_bits[0])
      |=> pin_out[0] == $past(periph_hi.dat[0]))
    else $error("High-priority peripheral did not own the pin.");

  // The strap and the reset-pin select steer the pull-ups; a strap that is
  // caught wrongly would leave board pads pulled that ought to float.
  a_gdis_pullup_off: assert property (
    pu_gdis |=> (pullup_on & ~gppa_pkg::INPUT_ONLY_MASK) == 8'h00)
    else $error("Pull-up on while the global disable is set.");

  a_reset_pin_pullup: assert property (
    external_reset_pin |=> pullup_on[gppa_pkg::INPUT_ONLY_POS])
    else $error("Reset-pin select did not turn on the pin five pull-up.");

  a_csrc_follow: assert property (
    current_source_on == $past({pullup_enable_bits[gppa_pkg::CSRC_HI_POS],
                                pullup_enable_bits[gppa_pkg::CSRC_LO_POS]}))
    else $error("Current source does not follow its enable bit.");

  a_od_release_four: assert property (
    (!pin_direction_bits[4] && port_latch[4] && !periph_hi.en[4] && !periph_lo.en[4])
      |=> !pin_oe[4])
    else $error("Open-drain pin four held low for a one.");

  a_od_sink_seven: assert property (
    (!pin_direction_bits[7] && !port_latch[7] && !periph_hi.en[7] && !periph_lo.en[7])
      |=> pin_oe[7])
    else $error("Open-drain pin seven did not sink for a zero.");

  a_analog_drive: assert property (
    (!pin_direction_bits[0] && analog_select_bits[0]) |=> pin_oe[0])
    else $error("Analog pin set as output was not driven.");

  c_data_write: cover property (wr_req.wr && wr_req.sel == gppa_pkg::GPPA_SEL_DATA);
  c_gdis_on: cover property (pu_gdis);
  c_change_seen: cover property (change_event != 8'h00);
  c_periph_drive: cover property (periph_hi.en[0] && pin_oe[0]);
  c_current_src: cover property (current_source_on == 2'h3);

endmodule : gppa_port

// file: test/gppa_board.sv
`timescale 1ns/1ns
// Board beside the port: an external driver per pad plus the pull-ups.
module gppa_board (
  input  wire logic       core_clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_on,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_drv,
  output logic      [7:0] pin_in
);
  logic [7:0] last; // Pad level seen at the previous edge.

  // Keep the last level so that a floating pad can be made to lose it.
  always_ff @(posedge core_clk)
  begin
    last <= pin_in;
  end

  // The port driver wins, then the external driver, then the pull-up.
  // A pad nobody holds shows its inverse last level, so a stale read fails.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val) |
                  (~pin_oe & ~ext_drv & (pullup_on | ~last));
endmodule : gppa_board

// file: test/gppa_port_tb.sv
`timescale 1ns/1ns
// Self-checking bench for the port, with random settings.
module gppa_port_tb;
  logic                   core_clk;    // Core clock.
  logic                   rst_n;       // Active-low reset.
  gppa_pkg::gppa_wr_s     wr_req;      // Write requests.
  gppa_pkg::gppa_rd_s     rd_view;     // Read-back view.
  gppa_pkg::gppa_periph_s periph_hi;   // Higher peripheral.
  gppa_pkg::gppa_periph_s periph_lo;   // Lower peripheral.
  logic                   ext_rst_sel; // Reset-pin selection.
  logic                   gdis;        // Global pull-up disable strap.
  logic [7:0]             pin_in;      // Resolved pads.
  logic [7:0]             pin_out;     // Pad values.
  logic [7:0]             pin_oe;      // Pad enables.
  logic [7:0]             pullup_on;   // Pull-up enables.
  logic [1:0]             csrc_on;     // Current sources.
  logic [7:0]             change_event;// Change pulses.
  logic [7:0]             ext_val;     // Board drive level.
  int                     errors;      // Mismatches.
  int                     comparisons; // Compares made.
  logic [31:0]            seed;        // Random state.

  gppa_port gppa_port_i (.core_clk(core_clk), .rst_n(rst_n), .wr_req(wr_req),
    .rd_view(rd_view), .periph_hi(periph_hi), .periph_lo(periph_lo),
    .external_reset_pin(ext_rst_sel), .pullup_global_disable(gdis), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
    .current_source_on(csrc_on), .change_event(change_event));

  gppa_board gppa_board_i (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_on(pullup_on), .ext_val(ext_val), .ext_drv(8'hff), .pin_in(pin_in));

  // Xorshift generator, so every run sees the same values.
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  // Enables: direction clear, never the input-only pin, open-drain only low.
  function automatic logic [7:0] exp_oe(logic [7:0] dir, logic [7:0] val);
    return ~dir & 8'hdf & ~(8'h90 & val);
  endfunction : exp_oe

  // Reports and counts one comparison.
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One write pulse, then time for register, view and pads to settle.
  task automatic wr(gppa_pkg::gppa_sel_e s, logic [7:0] d, logic [7:0] m);
    @(posedge core_clk);
    wr_req <= '{wr: 1'b1, sel: s, data: d, mask: m};
    @(posedge core_clk);
    wr_req.wr <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1;
  endtask : wr

  // The single place where the run ends.
  task automatic end_sim();
    if (errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    #100000;
    errors++;
    end_sim();
  end

  initial
  begin
    logic [7:0] d, l, a, p, v, hen, hd, len, ld;
    int         cnt;
    errors = 0;
    comparisons = 0;
    seed = 32'd56027;
    rst_n = 1'b0;
    wr_req = '{wr: 1'b0, sel: gppa_pkg::GPPA_SEL_DIR, data: 8'h00, mask: 8'h00};
    periph_hi = '{en: 8'h00, dat: 8'h00};
    periph_lo = '{en: 8'h00, dat: 8'h00};
    ext_rst_sel = 1'b0;
    gdis = 1'b0;
    ext_val = 8'h00;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk("dir", rd_view.dir, 8'hff);
    chk("ansel", rd_view.ansel, 8'hff);
    chk("ioc", rd_view.ioc, 8'h00);
    chk("data", rd_view.data, 8'h00);
    chk("oe", pin_oe, 8'h00);
    // Pads change first, so the synchroniser has settled before the latch write.
    ext_val <= 8'h5a;
    // Digital inputs need analog select cleared first.
    wr(gppa_pkg::GPPA_SEL_ANSEL, 8'h00, 8'hff);
    // A write with no bits masked in loads the pin levels into the latch.
    wr(gppa_pkg::GPPA_SEL_DATA, 8'hff, 8'h00);
    chk("data", rd_view.data, 8'h5a);
    wr(gppa_pkg::GPPA_SEL_DIR, 8'h00, 8'hff);
    chk("out rmw", pin_out, 8'h4a);
    // Random direction, latch, analog, pull-up and peripheral settings.
    for (int i = 0; i < 40; i++)
    begin
      d = rnd();
      l = rnd();
      a = rnd();
      p = rnd();
      hen = (i < 10) ? 8'h00 : rnd();
      hd = rnd();
      len = (i < 10) ? 8'h00 : rnd();
      ld = rnd();
      @(posedge core_clk);
      ext_val <= rnd();
      ext_rst_sel <= rnd() > 8'h7f;
      periph_hi <= '{en: hen, dat: hd};
      periph_lo <= '{en: len, dat: ld};
      wr(gppa_pkg::GPPA_SEL_DIR, d, 8'hff);
      wr(gppa_pkg::GPPA_SEL_DATA, l, 8'hff);
      wr(gppa_pkg::GPPA_SEL_ANSEL, a, 8'hff);
      wr(gppa_pkg::GPPA_SEL_WPU, p, 8'hff);
      v = (hen & hd) | (~hen & len & ld) | (~hen & ~len & l);
      chk("dir", rd_view.dir, d | 8'h20);
      chk("oe", pin_oe, exp_oe(d | 8'h20, v));
      chk("out", pin_out, v & 8'h4f);
      chk("data", rd_view.data, ((exp_oe(d | 8'h20, v) & v) |
          (~exp_oe(d | 8'h20, v) & ext_val)) & ~a);
      chk("pullup", pullup_on, (p & 8'h03 & d) |
          ((p[5] | ext_rst_sel) ? 8'h20 : 8'h00));
      chk("csrc", {6'h00, csrc_on}, {6'h00, p[3:2]});
      chk("wpu", rd_view.wpu, p);
      chk("ansel", rd_view.ansel, a);
    end
    // Change pulses only from pins whose enable is set.
    @(posedge core_clk);
    periph_hi <= '{en: 8'h00, dat: 8'h00};
    periph_lo <= '{en: 8'h00, dat: 8'h00};
    wr(gppa_pkg::GPPA_SEL_DIR, 8'hff, 8'hff);
    wr(gppa_pkg::GPPA_SEL_ANSEL, 8'h00, 8'hff);
    for (int i = 0; i < 8; i++)
    begin
      wr(gppa_pkg::GPPA_SEL_IOC, 8'h01 << i, 8'hff);
      chk("ioc", rd_view.ioc, 8'h01 << i);
      ext_val <= ext_val ^ 8'hff;
      cnt = 0;
      repeat (8)
      begin
        @(posedge core_clk);
        #1;
        cnt += (change_event == (8'h01 << i));
        chk("event mask", change_event & ~(8'h01 << i), 8'h00);
      end
      chk("event count", cnt[7:0], 8'h01);
    end
    // A mid-run reset with the global pull-up disable strapped on.
    @(posedge core_clk);
    rst_n <= 1'b0;
    gdis <= 1'b1;
    ext_rst_sel <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk("dir", rd_view.dir, 8'hff);
    chk("ansel", rd_view.ansel, 8'hff);
    chk("ioc", rd_view.ioc, 8'h00);
    chk("wpu", rd_view.wpu, 8'h00);
    chk("oe", pin_oe, 8'h00);
    // Every pull-up enable set, yet the strap keeps all pull-ups dark.
    wr(gppa_pkg::GPPA_SEL_WPU, 8'hff, 8'hff);
    chk("pullup gdis", pullup_on, 8'h00);
    chk("csrc", {6'h00, csrc_on}, 8'h03);
    // The reset-pin select still turns on the pull-up of pin 5.
    @(posedge core_clk);
    ext_rst_sel <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk("pullup rst pin", pullup_on, 8'h20);
    end_sim();
  end
endmodule : gppa_port_tb
